// ===== logic/pco_overflow_irq.sv
// What this block does
// RL1: bit j of group x word serves counter x*32+j; bits m..31 read zero, ignore writes.
// RL2: enable-clear view: write 1 disables that counter's request; read shows enable.
// RL3: enable-set view: write 1 enables that counter's request; read shows enable.
// RL4: both enable views share one enable bit per counter.
// RL5: request raised while a counter has overflowed and its request is enabled.
// RL6: software writes 1 to overflow-clear; that counter stops contributing to the request.
// RL7: overflow-clear view: write 1 clears overflow status; write 0 does nothing.
// RL8: overflow-set view lets software force overflow status by writing.
// RL9: reads of either overflow view return current overflow status.
// RL10: registers are 32-bit read/write; reset value undefined, software initialises; the block resets enable and overflow bits to zero.
// RL11: overflow request leaves the block as an output pin.
// RL12: overflow-set view: write 1 sets status; write 0 ignored.
// RL13: counter wrap indication sets that counter's overflow status bit.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
module pco_overflow_irq #(
  parameter int NUM_CNT = 40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [pco_pkg::PCO_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [pco_pkg::PCO_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [pco_pkg::PCO_DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // counter wrap pulses
  input wire logic [NUM_CNT-1:0] cnt_wrap,
  // requests
  output logic ovf_irq,
  output logic irq
);
  import pco_pkg::*;

  localparam int NGRP = (NUM_CNT + 31) / 32;
  localparam int NBITS = NGRP * 32;

  logic [NBITS-1:0] en_reg, en_next;
  logic [NBITS-1:0] ov_reg, ov_next;
  logic [PCO_STS_W-1:0] sts_reg, sts_next, msk_reg, msk_next;
  logic wr_pend_reg, wr_pend_next;
  logic [PCO_ADDR_W-1:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [NBITS-1:0] impl_mask;

  // unimplemented counters are tied off so they read zero and ignore writes
  genvar g;
  generate
    for (g = 0; g < NBITS; g++) begin : g_mask
      assign impl_mask[g] = (g < NUM_CNT) ? 1'b1 : 1'b0; // [RL1]
    end
  endgenerate

  logic [NBITS-1:0] wrap_ext;
  assign wrap_ext = {{(NBITS-NUM_CNT){1'b0}}, cnt_wrap} ;

  // decode of the address phase
  logic ap_valid, ap_wr, ap_rd, ap_bad;
  logic [PCO_ADDR_W-1:0] ap_off;
  logic [PCO_ADDR_W-1:0] ap_grp;
  logic ap_in_bank;
  always_comb begin
    ap_valid = hsel && hready && (htrans == PCO_HTRANS_NONSEQ || htrans == PCO_HTRANS_SEQ);
    ap_off = haddr & 12'h00F;
    ap_grp = haddr >> PCO_GRP_SHIFT;
    ap_in_bank = (haddr < PCO_OFS_IRQ_STS) && (int'(ap_grp) < NGRP);
    ap_bad = ap_valid && (hsize != {1'b0, PCO_HSIZE_WORD});
    ap_wr = ap_valid && hwrite && !ap_bad;
    ap_rd = ap_valid && !hwrite;
  end

  function automatic logic [31:0] grp_word(input logic [NBITS-1:0] v, input logic [PCO_ADDR_W-1:0] grp);
    logic [31:0] w;
    w = 32'h00000000;
    for (int k = 0; k < NGRP; k++) begin
      if (grp == PCO_ADDR_W'(k)) begin
        w = v[k*32 +: 32];
      end
    end
    return w;
  endfunction : grp_word

  // write data phase and hardware events
  logic [PCO_ADDR_W-1:0] wr_grp, wr_off;
  logic [NBITS-1:0] wr_spread;
  logic [PCO_STS_W-1:0] ev;
  always_comb begin
    wr_grp = addr_reg >> PCO_GRP_SHIFT;
    wr_off = addr_reg & 12'h00F;
    wr_spread = '0;
    for (int k = 0; k < NGRP; k++) begin
      if (wr_grp == PCO_ADDR_W'(k) && addr_reg < PCO_OFS_IRQ_STS) begin
        wr_spread[k*32 +: 32] = hwdata;
      end
    end
    wr_spread = wr_spread & impl_mask; // [RL1]
    en_next = en_reg;
    ov_next = ov_reg;
    msk_next = msk_reg;
    sts_next = sts_reg;
    wr_pend_next = ap_wr;
    addr_next = ap_valid ? haddr : addr_reg;
    if (wr_pend_reg) begin
      case (wr_off)
        PCO_OFS_EN_SET: en_next = en_reg | wr_spread; // [RL3] [RL4]
        PCO_OFS_EN_CLR: en_next = en_reg & ~wr_spread; // [RL2] [RL4]
        PCO_OFS_OV_SET: ov_next = ov_reg | wr_spread; // [RL8] [RL12]
        PCO_OFS_OV_CLR: ov_next = ov_reg & ~wr_spread; // [RL6] [RL7]
        default: ;
      endcase
      if (addr_reg == PCO_OFS_IRQ_MSK) begin
        msk_next = hwdata[PCO_STS_W-1:0];
      end
      if (addr_reg == PCO_OFS_IRQ_STS) begin
        sts_next = sts_reg & ~hwdata[PCO_STS_W-1:0];
      end
    end
    // a wrap in the same cycle as a clear wins
    ov_next = (ov_next | (wrap_ext & impl_mask)) & impl_mask; // [RL13] [RL1]
    en_next = en_next & impl_mask;
    ev = '0;
    ev[PCO_STS_OVF] = |(wrap_ext & impl_mask);
    ev[PCO_STS_BADACC] = ap_bad || (ap_valid && !ap_in_bank && haddr != PCO_OFS_IRQ_STS
                          && haddr != PCO_OFS_IRQ_MSK);
    sts_next = sts_next | ev;
    // read data registered at the address phase, shown in the data phase
    rdata_next = rdata_reg;
    if (ap_rd) begin
      if (haddr == PCO_OFS_IRQ_STS) begin
        rdata_next = 32'(sts_reg);
      end else if (haddr == PCO_OFS_IRQ_MSK) begin
        rdata_next = 32'(msk_reg);
      end else if (!ap_in_bank) begin
        rdata_next = 32'h00000000;
      end else if (ap_off == PCO_OFS_EN_SET || ap_off == PCO_OFS_EN_CLR) begin
        rdata_next = grp_word(en_reg, ap_grp); // [RL2] [RL3] [RL4]
      end else if (ap_off == PCO_OFS_OV_SET || ap_off == PCO_OFS_OV_CLR) begin
        rdata_next = grp_word(ov_reg, ap_grp); // [RL9]
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  // enable and overflow bits have no defined reset value;
  // they are zeroed anyway so simulation starts clean; software must still init [RL10]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_reg <= '0;
      ov_reg <= '0;
      sts_reg <= '0;
      msk_reg <= '0;
      wr_pend_reg <= 1'b0;
      addr_reg <= '0;
      rdata_reg <= PCO_RESET_VAL;
    end else begin
      en_reg <= en_next;
      ov_reg <= ov_next;
      sts_reg <= sts_next;
      msk_reg <= msk_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ovf_irq = |(ov_reg & en_reg); // [RL5] [RL6] [RL11]
  assign irq = |(sts_reg & msk_reg);
endmodule : pco_overflow_irq

// ===== logic/pco_pkg.sv
package pco_pkg;
  localparam int PCO_DATA_W = 32;
  localparam int PCO_ADDR_W = 12;
  // one word per register group x; groups placed at a stride of 16 bytes
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_EN_SET = 12'h000;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_EN_CLR = 12'h004;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_OV_SET = 12'h008;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_OV_CLR = 12'h00C;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_IRQ_STS = 12'h100;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_IRQ_MSK = 12'h104;
  localparam int PCO_GRP_SHIFT = 4;
  localparam int PCO_SEL_LSB = 2;
  localparam logic [1:0] PCO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PCO_HTRANS_SEQ = 2'h3;
  localparam logic [1:0] PCO_HSIZE_WORD = 2'h2;
  localparam logic [31:0] PCO_RESET_VAL = 32'h00000000;
  // irq status bits
  localparam int PCO_STS_OVF = 0;
  localparam int PCO_STS_BADACC = 1;
  localparam int PCO_STS_W = 2;
endpackage : pco_pkg

// ===== testbench/pco_intc.sv
module pco_intc (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request in, sticky capture out
  input wire logic req,
  output logic seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // sticky so a short request is not lost between bench samples
  always_ff @(posedge ref_clk) seen <= rst ? 1'b0 : (seen | req);
endmodule : pco_intc

// ===== testbench/pco_chk_asserts.sv
module pco_chk #(parameter int NUM_CNT = 40) (
  // bus
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [11:0] haddr,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // events
  input wire logic [NUM_CNT-1:0] cnt_wrap,
  input wire logic ovf_irq,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic v;
  logic w;
  logic [3:0] a;
  default clocking @(posedge ref_clk); endclocking
  default disable iff rst;
  // data phase trackers: effects land one cycle after the data phase
  always_ff @(posedge ref_clk) begin
    v <= hsel && htrans[1];
    w <= hsel && htrans[1] && hwrite;
    a <= haddr[3:0];
  end
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus wait or error");
  property p_rst; disable iff (1'b0) rst |=> !ovf_irq && !irq; endproperty
  a_rst: assert property (p_rst) else $error("request during reset");
  property p_chg; $changed(ovf_irq) |-> $past(w || |cnt_wrap); endproperty
  a_chg: assert property (p_chg) else $error("request moved without cause");
  property p_up; $rose(ovf_irq) |-> $past(|cnt_wrap || w && !a[2]); endproperty
  a_up: assert property (p_up) else $error("request rose without set");
  property p_dn; $fell(ovf_irq) |-> $past(w && a[2]); endproperty
  a_dn: assert property (p_dn) else $error("request fell without clear");
  property p_irq; $rose(irq) |-> $past(|cnt_wrap || hsel && htrans[1] || v); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
  property p_irqdn; $fell(irq) |-> $past(w); endproperty
  a_irqdn: assert property (p_irqdn) else $error("irq fell without write");
  property p_hold; !$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : pco_chk
bind pco_overflow_irq pco_chk #(.NUM_CNT(NUM_CNT)) u_chk (.*);

// ===== testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pco_pkg::*;
  localparam int NC = 40;
  localparam logic [63:0] M = (64'h1 << NC) - 64'h1;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp, ovf_irq, irq, seen;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0, hrdata, q, d;
  logic [NC-1:0] cnt_wrap = 0;
  logic [63:0] en = 0, ov = 0, r;
  int n_fail = 0, cmp_count = 0, seed = 40970, k, g, v, w;
  always #5 ref_clk = ~ref_clk;
  pco_overflow_irq #(.NUM_CNT(NC)) DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .cnt_wrap(cnt_wrap), .ovf_irq(ovf_irq), .irq(irq));
  pco_intc u_ic (.ref_clk(ref_clk), .rst(rst), .req(ovf_irq), .seen(seen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] exp_rd(input int vv, input int gg);
    return vv < 2 ? en[gg*32 +: 32] : ov[gg*32 +: 32];
  endfunction : exp_rd
  task wrap_up;
    $display("mismatches %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task rdy;
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      wrap_up;
    end
  endtask : rdy
  // idle cycle first so a read always sees the previous write
  task xfer(input logic wr, input logic [11:0] ad, input logic [31:0] dat);
    @(posedge ref_clk);
    hsel <= 1;
    haddr <= ad;
    htrans <= PCO_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= dat;
    rdy;
    q = hrdata;
  endtask : xfer
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    for (k = 0; k < 4; k++) xfer(1, 12'(4 + 8 * k), '1);
    xfer(1, PCO_OFS_IRQ_MSK, 32'h1);
    for (k = 0; k < 30; k++) begin
      g = $unsigned($random(seed)) % 2;
      v = $unsigned($random(seed)) % 4;
      w = $unsigned($random(seed)) % NC;
      d = k < 2 ? '1 : $random(seed);
      cnt_wrap[w] <= 1'b1;
      @(posedge ref_clk);
      cnt_wrap <= '0;
      ov[w] = 1'b1;
      xfer(1, 12'(g * 16 + v * 4), d);
      r = (64'(d) << (g * 32)) & M;
      case (v)
        0: en |= r;
        1: en &= ~r;
        2: ov |= r;
        default: ov &= ~r;
      endcase
      @(posedge ref_clk);
      chk(ovf_irq, |(en & ov));
      chk(irq, 1);
      xfer(1, PCO_OFS_IRQ_STS, 32'h1);
      @(posedge ref_clk);
      chk(irq, 0);
      chk(hresp, 0);
      for (v = 0; v < 4; v++) begin
        xfer(0, 12'(g * 16 + v * 4), 0);
        chk(q, exp_rd(v, g));
      end
    end
    xfer(1, PCO_OFS_EN_SET, '1);
    xfer(1, PCO_OFS_OV_SET, 32'h1);
    @(posedge ref_clk);
    chk(ovf_irq, 1);
    xfer(1, PCO_OFS_OV_CLR, '1);
    xfer(1, PCO_OFS_OV_CLR + 12'h010, '1);
    @(posedge ref_clk);
    chk(ovf_irq, 0);
    chk(seen, 1);
    wrap_up;
  end
endmodule : tb
